// *** cia_pkg.sv ***
// Purpose: Shared constants and types for the channel interrupt aggregator
// Assumes: APB, 32-bit data, register index times four is the byte address
// Notes:   Channels 6 to 11 map to bit 0 to bit 5
`default_nettype none
package cia_pkg;
   // ------------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------------
   localparam int NCH    = 6;
   localparam int ADDR_W = 10;
   // ------------------------------------------------------------------
   // Register indices (byte address = index * 4)
   // ------------------------------------------------------------------
   localparam logic [7:0] IDX_PART_ID  = 8'h6e;
   localparam logic [7:0] IDX_CH_EN    = 8'he0;
   localparam logic [7:0] IDX_CH_STAT  = 8'he1;
   localparam logic [7:0] IDX_EVT_STAT = 8'hf0;
   localparam logic [7:0] IDX_EVT_MASK = 8'hf1;
   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [5:0]  CH_EN_RST    = 6'h00;
   localparam logic [5:0]  EVT_MASK_RST = 6'h00;
   localparam logic [5:0]  EVT_STAT_RST = 6'h00;
   localparam logic [31:0] PRDATA_RST   = 32'h0000_0000;
   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [NCH-1:0] pending;   // Enabled source interrupt pending, per channel
      logic [NCH-1:0] src_read;  // Pulse: host read that channel's source status
   } cia_chan_in_t;
endpackage : cia_pkg
`default_nettype wire

// *** cia_chan.sv ***
// Purpose: Sticky pending flag for one channel
// Assumes: Inputs come from logic on pclk
// Notes:   A new pending level in the clearing cycle keeps the flag set
`timescale 1ns/1ps
`default_nettype none
module cia_chan (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pending,
   input  wire logic src_read,
   output var  logic status_reg
);
   // ------------------------------------------------------------------
   // Flag
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= 1'b0;
      end else begin
         status_reg <= pending | (status_reg & ~src_read); // see R5, see R6
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   property p_set_on_pending;
      @(posedge pclk) disable iff (!presetn)
      pending |=> status_reg;
   endproperty
   a_set_on_pending: assert property (p_set_on_pending) // see R5
      else $error("pending channel did not set its status");

   property p_hold_until_read;
      @(posedge pclk) disable iff (!presetn)
      (status_reg && !src_read) |=> status_reg;
   endproperty
   a_hold_until_read: assert property (p_hold_until_read) // see R6
      else $error("status cleared without a source read");

   property p_clear_on_read;
      @(posedge pclk) disable iff (!presetn)
      (src_read && !pending) |=> !status_reg;
   endproperty
   a_clear_on_read: assert property (p_clear_on_read) // see R6
      else $error("status not cleared after source read");
endmodule : cia_chan
`default_nettype wire

// *** cia_top.sv ***
// Purpose: Channel-level interrupt aggregation for channels 6 to 11
// Assumes: Channel inputs are on pclk; source-level gating done upstream
// Notes:   APB slave answers with pready in the first access cycle
//
// Summary of operation
// R1: Read/write master enable, bits 0-5 channels 6-11
// R2: Cleared enable blocks that channel from host pin
// R3: Set enable lets pending channel drive host pin
// R4: Read-only status, bits 0-5 channels 6-11
// R5: Status reads one while channel interrupt pending
// R6: Status holds until source status register read
// R7: Upper channels here, lower six elsewhere
// R8: Host then reads channel source status register
// R9: Fixed read-only part identification byte
// R10: Read-only and reserved bits ignore writes, read zero
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module cia_top
   import cia_pkg::*;
#(
   parameter logic [7:0] PART_ID = 8'h5a  // Arbitrary neutral value
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic [31:0]         pwdata,
   output var  logic [31:0]         prdata,
   output var  logic                pready,
   output var  logic                pslverr,
   input  wire cia_pkg::cia_chan_in_t chan_in,
   output var  logic                host_int,
   output var  logic                irq
);
   import cia_pkg::*;

   logic [NCH-1:0] ch_en_reg;
   logic [NCH-1:0] evt_mask_reg;
   logic [NCH-1:0] evt_stat_reg;
   logic [NCH-1:0] evt_stat_next;
   logic [NCH-1:0] ch_stat;
   logic [NCH-1:0] ch_stat_prev_reg;
   logic [NCH-1:0] ch_rise;
   logic [31:0]    rd_data;
   logic           hit;
   logic           setup;
   logic           wr;
   logic [7:0]     idx;

   assign idx   = paddr[9:2];
   assign setup = psel & ~penable;
   assign wr    = psel & penable & pready & pwrite & ~pslverr;

   // ------------------------------------------------------------------
   // Channel flags
   // ------------------------------------------------------------------
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      cia_chan u_ch (
         .pclk       (pclk),
         .presetn    (presetn),
         .pending    (chan_in.pending[i]),
         .src_read   (chan_in.src_read[i]),
         .status_reg (ch_stat[i])
      );
   end

   // ------------------------------------------------------------------
   // Read decode
   // ------------------------------------------------------------------
   always_comb begin
      rd_data = 32'h0000_0000; // see R10
      hit     = 1'b1;
      unique case (idx)
         IDX_PART_ID:  rd_data[7:0]     = PART_ID;      // see R9
         IDX_CH_EN:    rd_data[NCH-1:0] = ch_en_reg;    // see R1
         IDX_CH_STAT:  rd_data[NCH-1:0] = ch_stat;      // see R4, see R7
         IDX_EVT_STAT: rd_data[NCH-1:0] = evt_stat_reg;
         IDX_EVT_MASK: rd_data[NCH-1:0] = evt_mask_reg;
         default:      hit              = 1'b0;
      endcase
   end

   // ------------------------------------------------------------------
   // APB answer
   // ------------------------------------------------------------------
   // Registered answer keeps every bus output straight from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= PRDATA_RST;
      end else if (setup) begin
         pready  <= 1'b1;
         pslverr <= ~hit;
         prdata  <= (pwrite || !hit) ? 32'h0000_0000 : rd_data;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Writable registers
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ch_en_reg <= CH_EN_RST;
      end else if (wr && idx == IDX_CH_EN) begin
         ch_en_reg <= pwdata[NCH-1:0]; // see R1, see R10
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_mask_reg <= EVT_MASK_RST;
      end else if (wr && idx == IDX_EVT_MASK) begin
         evt_mask_reg <= pwdata[NCH-1:0];
      end
   end

   // ------------------------------------------------------------------
   // Event status, write one to clear, new event wins
   // ------------------------------------------------------------------
   // Rising status only, so a flag that stays set does not refire
   assign ch_rise = ch_stat & ~ch_stat_prev_reg;

   always_comb begin
      evt_stat_next = evt_stat_reg;
      if (wr && idx == IDX_EVT_STAT) begin
         evt_stat_next = evt_stat_reg & ~pwdata[NCH-1:0];
      end
      evt_stat_next = evt_stat_next | ch_rise;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_stat_reg     <= EVT_STAT_RST;
         ch_stat_prev_reg <= '0;
      end else begin
         evt_stat_reg     <= evt_stat_next;
         ch_stat_prev_reg <= ch_stat;
      end
   end

   // ------------------------------------------------------------------
   // Interrupt outputs
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_int <= 1'b0;
         irq      <= 1'b0;
      end else begin
         host_int <= |(ch_stat & ch_en_reg); // see R2, see R3
         irq      <= |(evt_stat_next & evt_mask_reg);
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   property p_pin_blocked;
      @(posedge pclk) disable iff (!presetn)
      ((ch_stat & ch_en_reg) == '0) |=> !host_int;
   endproperty
   a_pin_blocked: assert property (p_pin_blocked) // see R2
      else $error("host pin high with no enabled pending channel");

   property p_pin_raised;
      @(posedge pclk) disable iff (!presetn)
      ((ch_stat & ch_en_reg) != '0) |=> host_int;
   endproperty
   a_pin_raised: assert property (p_pin_raised) // see R3
      else $error("host pin low with enabled pending channel");

   property p_en_write;
      @(posedge pclk) disable iff (!presetn)
      (wr && idx == IDX_CH_EN) |=> (ch_en_reg == $past(pwdata[NCH-1:0]));
   endproperty
   a_en_write: assert property (p_en_write) // see R1
      else $error("enable register did not take written value");

   property p_stat_read;
      @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && idx == IDX_CH_STAT)
         |=> pready && prdata == {26'h0, $past(ch_stat)};
   endproperty
   a_stat_read: assert property (p_stat_read) // see R4
      else $error("status read returned wrong data");

   property p_id_read;
      @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && idx == IDX_PART_ID) |=> prdata == {24'h0, PART_ID};
   endproperty
   a_id_read: assert property (p_id_read) // see R9
      else $error("part identification read wrong");

   property p_ro_write;
      @(posedge pclk) disable iff (!presetn)
      (wr && (idx == IDX_CH_STAT || idx == IDX_PART_ID)) |=> $stable(ch_en_reg);
   endproperty
   a_ro_write: assert property (p_ro_write) // see R10
      else $error("read-only write changed enable register");

   property p_en_read;
      @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && idx == IDX_CH_EN) |=> prdata[31:NCH] == '0;
   endproperty
   a_en_read: assert property (p_en_read) // see R10
      else $error("reserved enable bits read nonzero");

   property p_unmapped;
      @(posedge pclk) disable iff (!presetn)
      (setup && !hit) |=> pready && pslverr;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access not flagged");

   // ------------------------------------------------------------------
   // Bus answer checks
   // ------------------------------------------------------------------
   property p_ready_once;
      @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
   endproperty
   a_ready_once: assert property (p_ready_once)
      else $error("ready stood for more than one cycle");

   property p_ready_after_setup;
      @(posedge pclk) disable iff (!presetn)
      setup |=> pready;
   endproperty
   a_ready_after_setup: assert property (p_ready_after_setup)
      else $error("no ready in first access cycle");

   // Idle bus must not see a stray answer
   property p_idle_quiet;
      @(posedge pclk) disable iff (!presetn)
      !psel |=> !pready && !pslverr;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("answer on an idle bus");

   property p_err_with_ready;
      @(posedge pclk) disable iff (!presetn)
      pslverr |-> pready;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready)
      else $error("error flag without ready");

   property p_mapped_no_err;
      @(posedge pclk) disable iff (!presetn)
      (setup && hit) |=> !pslverr;
   endproperty
   a_mapped_no_err: assert property (p_mapped_no_err)
      else $error("mapped access flagged as error");

   property p_write_data_zero;
      @(posedge pclk) disable iff (!presetn)
      (setup && pwrite) |=> prdata == '0;
   endproperty
   a_write_data_zero: assert property (p_write_data_zero)
      else $error("read data not zero on a write");

   property p_stat_reserved;
      @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && idx == IDX_CH_STAT) |=> prdata[31:NCH] == '0;
   endproperty
   a_stat_reserved: assert property (p_stat_reserved) // see R10
      else $error("reserved status bits read nonzero");

   // ------------------------------------------------------------------
   // Event and interrupt checks
   // ------------------------------------------------------------------
   property p_mask_write;
      @(posedge pclk) disable iff (!presetn)
      (wr && idx == IDX_EVT_MASK) |=> (evt_mask_reg == $past(pwdata[NCH-1:0]));
   endproperty
   a_mask_write: assert property (p_mask_write)
      else $error("mask register did not take written value");

   // A clear in the same cycle must not lose the new event
   property p_evt_set;
      @(posedge pclk) disable iff (!presetn)
      (ch_rise != '0) |=> (evt_stat_reg & $past(ch_rise)) == $past(ch_rise);
   endproperty
   a_evt_set: assert property (p_evt_set)
      else $error("new event not latched");

   property p_evt_clear;
      @(posedge pclk) disable iff (!presetn)
      (wr && idx == IDX_EVT_STAT && ch_rise == '0)
         |=> (evt_stat_reg & $past(pwdata[NCH-1:0])) == '0;
   endproperty
   a_evt_clear: assert property (p_evt_clear)
      else $error("written one did not clear event");

   property p_evt_hold;
      @(posedge pclk) disable iff (!presetn)
      !(wr && idx == IDX_EVT_STAT)
         |=> (evt_stat_reg & $past(evt_stat_reg)) == $past(evt_stat_reg);
   endproperty
   a_evt_hold: assert property (p_evt_hold)
      else $error("event cleared without a write");

   property p_irq_level;
      @(posedge pclk) disable iff (!presetn)
      irq == |(evt_stat_reg & $past(evt_mask_reg));
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt level disagrees with events");

   property p_irq_masked;
      @(posedge pclk) disable iff (!presetn)
      (evt_mask_reg == '0) |=> !irq;
   endproperty
   a_irq_masked: assert property (p_irq_masked)
      else $error("interrupt high with all events masked");
endmodule : cia_top
`default_nettype wire

// *** cia_src_model.sv ***
// Purpose: Source-level interrupt logic model feeding the channel inputs
// Assumes: Bench requests are taken on pclk rising edges
// Notes:   A source read clears the pending level in the same edge
`timescale 1ns/1ps
`default_nettype none
module cia_src_model
   import cia_pkg::*;
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic [cia_pkg::NCH-1:0] raise,
   input  wire logic [cia_pkg::NCH-1:0] drop,
   input  wire logic [cia_pkg::NCH-1:0] rd_req,
   output var  cia_pkg::cia_chan_in_t chan_in
);
   // ------------------------------------------------------------------
   // Pending sources and read strobes
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_in <= '0;
      end else begin
         // Only source-enabled events reach here, so gating is upstream
         chan_in.pending  <= (chan_in.pending & ~rd_req & ~drop) | raise;
         chan_in.src_read <= rd_req;
      end
   end
endmodule : cia_src_model
`default_nettype wire

// *** cia_tb.sv ***
// Purpose: Self-checking bench for the channel interrupt aggregator
// Assumes: Zero-wait APB slave, pready sampled at the access edge
// Notes:   Drop without a source read must leave the status set
`timescale 1ns/1ps
`default_nettype none
module tb;
   import cia_pkg::*;
   localparam logic [7:0] PID = 8'h3c;  // Arbitrary value
   logic                  pclk = 1'b0;
   logic                  presetn = 1'b0;
   logic                  psel = 1'b0;
   logic                  penable = 1'b0;
   logic                  pwrite = 1'b0;
   logic [ADDR_W-1:0]     paddr = '0;
   logic [31:0]           pwdata = '0;
   logic [31:0]           prdata;
   logic                  pready;
   logic                  pslverr;
   logic                  err_seen;
   logic [NCH-1:0]        raise = '0;
   logic [NCH-1:0]        drop = '0;
   logic [NCH-1:0]        rd_req = '0;
   cia_chan_in_t          chan_in;
   logic                  host_int;
   logic                  irq;
   int                    mismatches = 0;
   int                    checked = 0;
   always #5 pclk = ~pclk;
   cia_src_model SRC (.pclk(pclk), .presetn(presetn), .raise(raise), .drop(drop),
                      .rd_req(rd_req), .chan_in(chan_in));
   cia_top #(.PART_ID(PID)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .chan_in(chan_in),
      .host_int(host_int), .irq(irq));
   // ------------------------------------------------------------------
   // Bus and compare tasks
   // ------------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         mismatches++;
         end_of_test();
      end
      rd       = prdata;
      err_seen = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
      logic [31:0] d;
      apb(1'b1, idx, wd, d);
   endtask : wr
   task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      apb(1'b0, idx, 32'h0, d);
      chk(d, exp);
   endtask : rc
   task automatic pulse(input int kind, input logic [NCH-1:0] v);
      @(posedge pclk);
      if (kind == 0) begin
         raise <= v;
      end else if (kind == 1) begin
         drop <= v;
      end else begin
         rd_req <= v;
      end
      @(posedge pclk);
      raise  <= '0;
      drop   <= '0;
      rd_req <= '0;
      repeat (3) @(posedge pclk);
   endtask : pulse
   task automatic end_of_test;
      if (mismatches == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test
   // ------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------
   initial begin
      #100us;
      mismatches++;
      end_of_test();
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rc(IDX_CH_EN, 32'h0);
      rc(IDX_CH_STAT, 32'h0);
      rc(IDX_PART_ID, {24'h0, PID});
      wr(IDX_CH_EN, 32'hffff_ffff);
      rc(IDX_CH_EN, 32'h3f);
      wr(IDX_PART_ID, 32'h0);
      rc(IDX_PART_ID, {24'h0, PID});
      wr(IDX_CH_STAT, 32'h3f);
      rc(IDX_CH_STAT, 32'h0);
      rc(8'h10, 32'h0);
      chk({31'h0, err_seen}, 32'h1);
      wr(IDX_EVT_MASK, 32'h01);
      pulse(0, 6'h21);
      rc(IDX_CH_STAT, 32'h21);
      chk({31'h0, host_int}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(IDX_CH_EN, 32'h20);
      repeat (2) @(posedge pclk);
      chk({31'h0, host_int}, 32'h1);
      wr(IDX_CH_EN, 32'h0);
      repeat (2) @(posedge pclk);
      chk({31'h0, host_int}, 32'h0);
      pulse(1, 6'h01);
      rc(IDX_CH_STAT, 32'h21);
      pulse(2, 6'h20);
      rc(IDX_CH_STAT, 32'h01);
      wr(IDX_CH_EN, 32'h01);
      repeat (2) @(posedge pclk);
      chk({31'h0, host_int}, 32'h1);
      pulse(2, 6'h01);
      rc(IDX_CH_STAT, 32'h0);
      chk({31'h0, host_int}, 32'h0);
      wr(IDX_EVT_STAT, 32'h3f);
      rc(IDX_EVT_STAT, 32'h0);
      chk({31'h0, irq}, 32'h0);
      end_of_test();
   end
endmodule : tb
`default_nettype wire
